// ===== include/cmpl_consts.svh
// Register offsets, field positions, reset values for the comparator control block
`ifndef CMPL_CONSTS_SVH
`define CMPL_CONSTS_SVH

`define CMPL_ADDR_W 4
`define CMPL_OFF_PWR_HYST 4'h0
`define CMPL_OFF_LATCH_SEL 4'h1
`define CMPL_OFF_PORTB_FUNC 4'h2
`define CMPL_OFF_PIN_FUNC 4'h3
`define CMPL_OFF_STATUS 4'h4

`define CMPL_PWR_HYST_RST 8'hF0
`define CMPL_LATCH_SEL_RST 8'h00
`define CMPL_PORTB_FUNC_RST 8'h00
`define CMPL_PIN_FUNC_RST 8'h00
// Analog control word after reset: power off, hysteresis on, separate negative inputs, no short
`define CMPL_ANALOG_RST 13'h01FC

`define CMPL_HYST_LSB 4
`define CMPL_PWR_LSB 0
`define CMPL_SEL3_LSB 6
`define CMPL_SEL2_LSB 4
`define CMPL_SEL1_LSB 2
`define CMPL_NEGSW_BIT 1
`define CMPL_PB_NEG_LSB 2
`define CMPL_PB_NEG_CODE 2'h2
`define CMPL_SEL_MASK 8'hFE

`endif

// ===== include/cmpl_pkg.sv
// Types shared by the comparator control block
package cmpl_pkg;

	typedef enum logic [1:0] {
		CMPL_GATE_DIRECT = 2'b00,
		CMPL_GATE_PWM = 2'b01,
		CMPL_GATE_HIGH = 2'b10,
		CMPL_GATE_LOW = 2'b11
	} cmpl_gate_e;

	// Motor drive signals used as latch gates
	typedef struct packed {
		logic [2:0] pwm_out;
		logic [2:0] high_drive;
		logic [2:0] low_drive;
	} cmpl_drive_s;

	// Analog controls toward the comparator cores
	typedef struct packed {
		logic [3:0] power_on;
		logic [3:0] hyst_on;
		logic [2:0] neg_input_on;
		logic common_neg_on;
		logic neg_short;
	} cmpl_analog_s;

endpackage

// ===== src/cmpl_ctrl.sv
// Comparator control wrapper: registers, latches, negative input switches
// Operation
// - Each comparator's power bit switches it on when 1 and fully off when 0.
// - Each comparator's hysteresis bit applies hysteresis when 1 and none when 0.
// - The control register holds hysteresis 3..0 in bits 7..4 and power 3..0 in bits 3..0, resetting to F0.
// - Comparator 3 select bits 7..6 pick direct, PWM channel 2, high-side OR or low-side OR.
// - Comparator 2 select bits 5..4 pick direct, PWM channel 1, high-side OR or low-side OR.
// - Comparator 1 select bits 3..2 pick direct, PWM channel 0, high-side OR or low-side OR.
// - Select bit 1 is the read/write common negative switch, bits 7..1 reset to zero.
// - Port B function code 10 in bits 3..2 shorts the three negative inputs onto the common pin.
// - A pin set to comparator input has its pull-high resistor disconnected.
// - A nonzero select makes the gate a transparent latch enable, holding while low.
// - Switch bit 0 enables separate negative inputs, 1 enables the common pin instead.
// - Select bit 0 is not implemented, reads zero and ignores writes.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "cmpl_consts.svh"

module cmpl_ctrl #(
	parameter int NUM_PINS = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register port
	input wire logic [`CMPL_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Motor drive gate sources
	input wire cmpl_pkg::cmpl_drive_s drive,
	// Comparator cores
	input wire logic [3:0] cmp_raw,
	output cmpl_pkg::cmpl_analog_s analog_r,
	output logic [3:0] cmp_out_r,
	// Pad pull-high control
	input wire logic [NUM_PINS-1:0] pull_high_req,
	output logic [NUM_PINS-1:0] pull_high_on_r
);

	logic [7:0] pwr_hyst_r;
	logic [7:0] latch_sel_r;
	logic [7:0] portb_func_r;
	logic [NUM_PINS-1:0] pin_cmp_r;
	logic [7:0] rdata_nxt;
	logic [3:0] cmp_path;
	logic [3:0] power_on;
	logic neg_short;
	logic high_or;
	logic low_or;

	logic wr_pwr;
	logic wr_sel;
	logic wr_pb;
	logic wr_pin;

	// Write decodes, one strobe per register
	assign wr_pwr = reg_wr && (reg_addr == `CMPL_OFF_PWR_HYST);
	assign wr_sel = reg_wr && (reg_addr == `CMPL_OFF_LATCH_SEL);
	assign wr_pb = reg_wr && (reg_addr == `CMPL_OFF_PORTB_FUNC);
	assign wr_pin = reg_wr && (reg_addr == `CMPL_OFF_PIN_FUNC);

	// Power and hysteresis register, all bits writable
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pwr_hyst_r <= `CMPL_PWR_HYST_RST;
		end else if (wr_pwr) begin
			pwr_hyst_r <= reg_wdata;
		end
	end

	// Latch select register, bit 0 masked off so it stays zero
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			latch_sel_r <= `CMPL_LATCH_SEL_RST;
		end else if (wr_sel) begin
			latch_sel_r <= reg_wdata & `CMPL_SEL_MASK;
		end
	end

	// Port B function select, only the comparator negative field is used here
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			portb_func_r <= `CMPL_PORTB_FUNC_RST;
		end else if (wr_pb) begin
			portb_func_r <= reg_wdata;
		end
	end

	// Per-pin comparator function flags, one bit per shared pad
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pin_cmp_r <= '0;
		end else if (wr_pin) begin
			pin_cmp_r <= reg_wdata[NUM_PINS-1:0];
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		case (reg_addr)
			`CMPL_OFF_PWR_HYST: rdata_nxt = pwr_hyst_r;
			`CMPL_OFF_LATCH_SEL: rdata_nxt = latch_sel_r; // Bit 0 always zero
			`CMPL_OFF_PORTB_FUNC: rdata_nxt = portb_func_r;
			`CMPL_OFF_PIN_FUNC: rdata_nxt = 8'(pin_cmp_r);
			`CMPL_OFF_STATUS: rdata_nxt = {4'h0, cmp_out_r};
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	assign power_on = pwr_hyst_r[`CMPL_PWR_LSB +: 4];
	// Common negative shorting needs the port B field at code 10
	assign neg_short = (portb_func_r[`CMPL_PB_NEG_LSB +: 2] == `CMPL_PB_NEG_CODE);

	// Analog controls registered so outputs come from flops
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			analog_r <= `CMPL_ANALOG_RST; // Mirrors register reset values
		end else begin
			analog_r.power_on <= power_on;
			analog_r.hyst_on <= pwr_hyst_r[`CMPL_HYST_LSB +: 4];
			analog_r.neg_input_on <= {3{~latch_sel_r[`CMPL_NEGSW_BIT]}};
			analog_r.common_neg_on <= latch_sel_r[`CMPL_NEGSW_BIT];
			analog_r.neg_short <= neg_short;
		end
	end

	// Pull-high dropped on any pad in comparator use
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pull_high_on_r <= '0;
		end else begin
			pull_high_on_r <= pull_high_req & ~pin_cmp_r;
		end
	end

	// Phase OR terms shared by all three latch paths
	assign high_or = |drive.high_drive;
	assign low_or = |drive.low_drive;

	// Comparator 0 has no latch, only power forcing
	// Forced by the flopped enable the core sees, so a waking core's junk never shows
	assign cmp_path[0] = analog_r.power_on[0] & cmp_raw[0];

	// Comparators 1..3 each get a gated output latch
	for (genvar i = 1; i < 4; i++) begin : g_lat
		cmpl_out_latch u_lat (
			.sys_clk(sys_clk),
			.reset(reset),
			.power_on(analog_r.power_on[i]),
			.gate_choice(cmpl_pkg::cmpl_gate_e'(latch_sel_r[2*i +: 2])),
			.pwm_gate(drive.pwm_out[i-1]),
			.high_or(high_or),
			.low_or(low_or),
			.cmp_raw(cmp_raw[i]),
			.cmp_out(cmp_path[i])
		);
	end

	// Registered result outputs; one cycle added after the latch stage
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmp_out_r <= 4'h0;
		end else begin
			cmp_out_r <= cmp_path;
		end
	end

endmodule
`default_nettype wire

// ===== src/cmpl_out_latch.sv
// One comparator output path: power forcing and gated transparent latch
`timescale 1ns/100ps
`default_nettype none
`include "cmpl_consts.svh"

module cmpl_out_latch (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Controls
	input wire logic power_on,
	input wire cmpl_pkg::cmpl_gate_e gate_choice,
	input wire logic pwm_gate,
	input wire logic high_or,
	input wire logic low_or,
	// Comparator result in and latched result out
	input wire logic cmp_raw,
	output logic cmp_out
);

	logic cmp_gated;
	logic gate;
	logic held_r;

	// Unpowered comparator reads low so a dead core never leaks noise
	assign cmp_gated = power_on & cmp_raw;

	// Gate source selection
	always_comb begin
		case (gate_choice)
			cmpl_pkg::CMPL_GATE_DIRECT: gate = 1'b1;
			cmpl_pkg::CMPL_GATE_PWM: gate = pwm_gate;
			cmpl_pkg::CMPL_GATE_HIGH: gate = high_or;
			cmpl_pkg::CMPL_GATE_LOW: gate = low_or;
			default: gate = 1'b1;
		endcase
	end

	// Clocked latch: follow while gate high, hold while low
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			held_r <= 1'b0;
		end else if (gate) begin
			held_r <= cmp_gated;
		end
	end

	// Direct code bypasses the hold register entirely
	// A closed gate may still hold a 1 from before power-down, so force low here too
	assign cmp_out = power_on & ((gate_choice == cmpl_pkg::CMPL_GATE_DIRECT) ? cmp_gated : held_r);

endmodule
`default_nettype wire

// ===== test/cmpl_core_model.sv
// Behavioural analog comparator cores
`timescale 1ns/100ps
`default_nettype none
module cmpl_core_model (
	// Core controls and results
	input wire logic [3:0] power_on,
	input wire logic [3:0] level,
	output logic [3:0] cmp_raw
);
	// An unpowered core gives junk, the inverse of its input
	assign cmp_raw = ~(power_on ^ level);
endmodule
`default_nettype wire

// ===== test/cmpl_ctrl_assertions.sv
// Port assertions for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module cmpl_ctrl_chk (
	// Clock, reset, register port, comparator side
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] cmp_raw,
	input wire cmpl_pkg::cmpl_analog_s analog_r,
	input wire logic [3:0] cmp_out_r
);
	// Short views of the analog controls
	wire logic [3:0] pw = analog_r.power_on;
	wire logic sh = analog_r.neg_short;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_rst_ctrl: assert property ($fell(reset) |-> analog_r.hyst_on == 4'hF && pw == 4'h0)
		else $error("bad control reset");
	a_rst_switch: assert property ($fell(reset) |-> analog_r.neg_input_on == 3'h7 && !sh)
		else $error("bad switch reset");
	a_sel_bit0: assert property ($past(reg_rd && reg_addr == 4'h1) |-> !reg_rdata[0])
		else $error("select bit 0 set");
	a_neg_pair: assert property (analog_r.neg_input_on == {3{!analog_r.common_neg_on}})
		else $error("inputs clash");
	a_power_write: assert property ($changed(pw) |-> $past(reg_wr && reg_addr == 4'h0, 2))
		else $error("power moved alone");
	a_short_write: assert property ($rose(sh) |-> $past(reg_wr && reg_addr == 4'h2, 2))
		else $error("short moved alone");
	a_off_low: assert property ((~pw & ~$past(pw) & cmp_out_r) == 4'h0) else $error("output high");
	a_cmp0_direct: assert property (pw[0] && $past(pw[0]) |-> cmp_out_r[0] == $past(cmp_raw[0]))
		else $error("comparator 0 lags");
	// Main scenarios reached
	c_sel_write: cover property (reg_wr && reg_addr == 4'h1);
	c_short_on: cover property (sh);
	c_out_fall: cover property ($fell(cmp_out_r[1]));
endmodule
bind cmpl_ctrl cmpl_ctrl_chk u_chk (.sys_clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .cmp_raw,
	.analog_r, .cmp_out_r);
`default_nettype wire

// ===== test/test_comparator_control_latch.sv
// Bench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; $display("mismatch at %0t: got %h want %h", $time, (a), (e)); end end
module test_comparator_control_latch;
	logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0, level = 4'h0, cmp_raw, cmp_out_r, ex;
	logic [7:0] reg_wdata = 8'h00, pull_high_req = 8'h00, reg_rdata, pull_high_on_r;
	logic [15:0] r = 16'h0007;
	cmpl_pkg::cmpl_drive_s drive = '0;
	cmpl_pkg::cmpl_analog_s analog_r;
	int bad_count = 0, check_count = 0;
	// Cores and the block
	cmpl_core_model core (.power_on(analog_r.power_on), .level, .cmp_raw);
	cmpl_ctrl dut (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .drive, .cmp_raw,
		.analog_r, .cmp_out_r, .pull_high_req, .pull_high_on_r);
	// 50 MHz clock
	initial forever #10 sys_clk = ~sys_clk;
	// Random source and expected latch gate
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic g(input logic [1:0] c, input int i, input cmpl_pkg::cmpl_drive_s d);
		return c == 2'h0 ? 1'b1 : c == 2'h1 ? d.pwm_out[i] : c == 2'h2 ? |d.high_drive : |d.low_drive;
	endfunction
	// Bus cycles and settling waits
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	// Gate settles before the input moves, so a closed latch must hold
	task automatic step(input logic [8:0] d, input logic [3:0] lv);
		@(posedge sys_clk);
		drive <= d;
		repeat (2) @(posedge sys_clk);
		level <= lv;
		tick(4);
	endtask
	task automatic tally_and_finish;
		$display("%0d checks %0d bad", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		rd(4'h0, 8'hF0);
		rd(4'h1, 8'h00);
		rd(4'h9, 8'h00);
		$display("reset done");
		repeat (12) begin
			r = nx(r);
			wr(4'h0, r[7:0]);
			wr(4'h1, r[15:8]);
			rd(4'h0, r[7:0]);
			rd(4'h1, r[15:8] & 8'hFE);
			`CHK(analog_r.power_on, r[3:0])
			`CHK(analog_r.hyst_on, r[7:4])
			`CHK(analog_r.common_neg_on, r[9])
		end
		$display("registers done");
		wr(4'h0, 8'h0F);
		for (int c = 0; c < 4; c++) begin
			wr(4'h1, {c[1:0], c[1:0], c[1:0], 2'h0});
			for (int n = 0; n < 6; n++) begin
				r = nx(r);
				step(n == 0 ? 9'h1FF : r[8:0], r[12:9]);
				ex[0] = level[0];
				for (int i = 1; i < 4; i++) if (g(c[1:0], i - 1, drive)) ex[i] = level[i];
				`CHK(cmp_out_r, ex)
				rd(4'h4, {4'h0, ex});
			end
		end
		$display("latch done");
		for (int c = 0; c < 4; c++) begin
			r = nx(r);
			wr(4'h2, {4'h0, c[1:0], 2'h0});
			wr(4'h3, r[7:0]);
			pull_high_req <= r[15:8];
			tick(3);
			`CHK(analog_r.neg_short, c == 2)
			`CHK(pull_high_on_r, r[15:8] & ~r[7:0])
			rd(4'h2, {4'h0, c[1:0], 2'h0});
			rd(4'h3, r[7:0]);
		end
		$display("pins done");
		step(9'h1FF, 4'hF);
		`CHK(cmp_out_r, 4'hF)
		@(posedge sys_clk);
		drive <= '0;
		wr(4'h0, 8'h00); // Cores off before stopping
		tick(4);
		`CHK(cmp_out_r, 4'h0)
		step(9'h1FF, 4'h0);
		`CHK(cmp_out_r, 4'h0)
		$display("power done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
